// file: design/cpd_pkg.sv
/*
 cpd_pkg: constants for the cpu power-down controller.
 assumes a 32-bit axi4-lite register bus and a 100 MHz core clock.
*/
package cpd_pkg;
	localparam int unsigned CPD_ADDR_W = 8;
	localparam logic [7:0] CPD_CSR_OFS = 8'h00;
	localparam logic [7:0] CPD_CTL_OFS = 8'h04;
	localparam logic [7:0] CPD_STS_OFS = 8'h08;
	localparam int unsigned CPD_FIELD_LSB = 10;
	localparam int unsigned CPD_FIELD_MSB = 15;
	localparam logic [5:0] CPD_FIELD_NONE = 6'h00;
	localparam logic [5:0] CPD_CODE_IRQ_EN = 6'h09;
	localparam logic [5:0] CPD_CODE_IRQ_ANY = 6'h11;
	localparam logic [5:0] CPD_CODE_PLL_OUT = 6'h1a;
	localparam logic [5:0] CPD_CODE_PLL_IN = 6'h1c;
	localparam logic [31:0] CPD_CSR_RST = 32'h0000_0000;
	localparam int unsigned CPD_GLOBAL_IRQ_BIT = 0;
	localparam int unsigned CPD_NONMASK_BIT = 1;
	localparam int unsigned CPD_EMU_BIT = 2;
	localparam int unsigned CPD_ENTRY_DLY = 9;
	localparam logic [1:0] CPD_RESP_OKAY = 2'h0;
	localparam logic [1:0] CPD_RESP_SLVERR = 2'h2;
	typedef enum logic [2:0] {
		CPD_RUN = 3'h0,
		CPD_WAIT = 3'h1,
		CPD_GATE_ST = 3'h2,
		CPD_PLL_OUT_ST = 3'h3,
		CPD_PLL_IN_ST = 3'h4
	} cpd_state_t;
endpackage

// file: design/cpd_entry_timer.sv
/*
 cpd_entry_timer: counts the entry delay after a field write.
 assumes start is a one-cycle pulse on ref_clk.
*/
`timescale 1ns/1ns
module cpd_entry_timer
	import cpd_pkg::*;
#(
	parameter int unsigned DELAY = CPD_ENTRY_DLY
) (
	input  wire logic ref_clk,
	input  wire logic sys_rst,
	input  wire logic start,
	input  wire logic cancel,
	output logic      done
);
	// counter is four bits wide
	if (DELAY < 1 || DELAY > 15) begin : g_bad_delay
		$error("cpd_entry_timer: DELAY out of range");
	end
	logic [3:0] cnt_q;
	logic       run_q;
	always_ff @(posedge ref_clk) begin
		if (sys_rst || cancel) begin
			cnt_q <= 4'h0;
			run_q <= 1'b0;
		end else if (start) begin
			cnt_q <= 4'h1;
			run_q <= 1'b1;
		end else if (run_q) begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'(DELAY)) run_q <= 1'b0;
		end
	end
	assign done = run_q && (cnt_q == 4'(DELAY)) && !start && !cancel;
endmodule

// file: design/cpd_ctrl.sv
/*
 cpd_ctrl: cpu power-down mode controller with axi4-lite registers.
 assumes one clock ref_clk, synchronous reset sys_rst, pin inputs synchronous.
*/
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
// Summary of operation
// - power-down field is bits 15..10
// - mode takes effect within nine cycles
// - unenabled wake resumes at stopping point
// - enabled wake runs service routine first
// - service needs global and nonmaskable enables
// - deep modes exit only by reset
// - code 001001 wakes on enabled interrupt
// - code 010001 wakes on any interrupt
// - dma keeps running in light mode
// - code 011010 stops pll output clock
// - code 011100 stops pll input clock
// - outputs freeze in deep modes
// - async peripherals may still toggle
// - emulator attached masks power-down modes
// - deep modes make emulation commands idle
`timescale 1ns/1ns
module cpd_ctrl
	import cpd_pkg::*;
#(
	parameter int unsigned ENTRY_DELAY = CPD_ENTRY_DLY
) (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        irq_pending,
	input  wire logic        irq_enabled,
	input  wire logic        emu_attached,
	input  wire logic        emu_exec_req,
	input  wire logic        emu_pc_write,
	output logic             cpu_clk_gate,
	output logic             cpu_halt,
	output logic             pll_out_stop,
	output logic             pll_in_stop,
	output logic             io_freeze,
	output logic             dma_allow,
	output logic             isr_take,
	output logic             resume_pulse,
	output logic             emu_spin_idle,
	output logic             emu_pc_fail
);
	// entry timer counts in four bits
	if (ENTRY_DELAY < 1 || ENTRY_DELAY > 15) begin : g_bad_delay
		$error("cpd_ctrl: ENTRY_DELAY out of range");
	end

	function automatic logic is_code(input logic [5:0] f);
		is_code = (f == CPD_CODE_IRQ_EN) || (f == CPD_CODE_IRQ_ANY) ||
			(f == CPD_CODE_PLL_OUT) || (f == CPD_CODE_PLL_IN);
	endfunction

	logic [31:0] csr_q;
	logic [31:0] ctl_q;
	logic        aw_q;
	logic        w_q;
	logic [7:0]  awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	cpd_state_t  st_q;
	logic [5:0]  mode_q;
	logic        emu_mask_q;
	logic        timer_start;
	logic        timer_done;
	logic        wr_go;
	logic        csr_hit;
	logic [5:0]  new_field;
	logic        wake_any;
	logic        service;

	logic        deep_st;

	assign deep_st = (st_q == CPD_PLL_OUT_ST) || (st_q == CPD_PLL_IN_ST);
	assign wr_go = aw_q && w_q && !s_axi_bvalid;
	assign csr_hit = wr_go && (awaddr_q == CPD_CSR_OFS);
	assign new_field = wstrb_q[1] ? wdata_q[CPD_FIELD_MSB:CPD_FIELD_LSB]
		: csr_q[CPD_FIELD_MSB:CPD_FIELD_LSB];
	assign timer_start = csr_hit && is_code(new_field) && (st_q == CPD_RUN);
	assign wake_any = irq_pending && (mode_q == CPD_CODE_IRQ_ANY || irq_enabled);
	assign service = irq_enabled && ctl_q[CPD_GLOBAL_IRQ_BIT] && ctl_q[CPD_NONMASK_BIT];

	cpd_entry_timer #(
		.DELAY (ENTRY_DELAY)
	) u_timer (
		.ref_clk (ref_clk),
		.sys_rst (sys_rst),
		.start   (timer_start),
		.cancel  (emu_mask_q),
		.done    (timer_done)
	);

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			emu_mask_q <= 1'b0;
		end else begin
			emu_mask_q <= emu_attached || ctl_q[CPD_EMU_BIT];
		end
	end

	// axi write channel
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			aw_q <= 1'b0;
			w_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h0000_0000;
			wstrb_q <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= CPD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_q <= 1'b1;
				awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_q <= 1'b1;
				wdata_q <= s_axi_wdata;
				wstrb_q <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_q <= 1'b0;
				w_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_q == CPD_CSR_OFS || awaddr_q == CPD_CTL_OFS ||
					awaddr_q == CPD_STS_OFS) ? CPD_RESP_OKAY : CPD_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	assign s_axi_awready = !aw_q && !s_axi_bvalid;
	assign s_axi_wready = !w_q && !s_axi_bvalid;

	// register storage
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			csr_q <= CPD_CSR_RST;
			ctl_q <= 32'h0000_0000;
		end else if (wr_go) begin
			if (awaddr_q == CPD_CSR_OFS) begin
				for (int b = 0; b < 4; b++) begin
					if (wstrb_q[b]) csr_q[b*8 +: 8] <= wdata_q[b*8 +: 8];
				end
				csr_q[CPD_FIELD_MSB] <= 1'b0;
			end else if (awaddr_q == CPD_CTL_OFS && wstrb_q[0]) begin
				ctl_q[CPD_EMU_BIT:0] <= wdata_q[CPD_EMU_BIT:0];
			end
		end else if (st_q == CPD_GATE_ST && wake_any) begin
			csr_q[CPD_FIELD_MSB:CPD_FIELD_LSB] <= CPD_FIELD_NONE;
		end
	end

	// axi read channel
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= CPD_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= CPD_RESP_OKAY;
			unique case ({s_axi_araddr[7:2], 2'b00})
				CPD_CSR_OFS: s_axi_rdata <= csr_q;
				CPD_CTL_OFS: s_axi_rdata <= ctl_q;
				CPD_STS_OFS: s_axi_rdata <= {22'h0, emu_mask_q, mode_q, st_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= CPD_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
	assign s_axi_arready = !s_axi_rvalid;

	// mode sequencer
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			st_q <= CPD_RUN;
			mode_q <= CPD_FIELD_NONE;
		end else begin
			unique case (st_q)
				CPD_RUN: begin
					if (timer_start && !emu_mask_q) begin
						st_q <= CPD_WAIT;
						mode_q <= new_field;
					end
				end
				CPD_WAIT: begin
					if (emu_mask_q) begin
						st_q <= CPD_RUN;
					end else if (timer_done) begin
						if (mode_q == CPD_CODE_PLL_OUT) st_q <= CPD_PLL_OUT_ST;
						else if (mode_q == CPD_CODE_PLL_IN) st_q <= CPD_PLL_IN_ST;
						else st_q <= CPD_GATE_ST;
					end
				end
				CPD_GATE_ST: begin
					if (wake_any || emu_mask_q) begin
						st_q <= CPD_RUN;
						mode_q <= CPD_FIELD_NONE;
					end
				end
				CPD_PLL_OUT_ST, CPD_PLL_IN_ST: st_q <= st_q;
				default: st_q <= CPD_RUN;
			endcase
		end
	end

	// outputs
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			cpu_clk_gate <= 1'b0;
			cpu_halt <= 1'b0;
			pll_out_stop <= 1'b0;
			pll_in_stop <= 1'b0;
			io_freeze <= 1'b0;
			dma_allow <= 1'b1;
			isr_take <= 1'b0;
			resume_pulse <= 1'b0;
			emu_spin_idle <= 1'b0;
			emu_pc_fail <= 1'b0;
		end else begin
			cpu_clk_gate <= (st_q == CPD_GATE_ST) && (mode_q == CPD_CODE_IRQ_ANY) && !wake_any;
			cpu_halt <= (st_q == CPD_GATE_ST && !wake_any) || deep_st;
			pll_out_stop <= st_q == CPD_PLL_OUT_ST;
			pll_in_stop <= st_q == CPD_PLL_IN_ST;
			io_freeze <= deep_st;
			dma_allow <= !deep_st;
			isr_take <= (st_q == CPD_GATE_ST) && wake_any && service;
			resume_pulse <= (st_q == CPD_GATE_ST) && wake_any;
			emu_spin_idle <= deep_st && emu_exec_req;
			emu_pc_fail <= deep_st && emu_pc_write;
		end
	end

	deep_sticky_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		deep_st |=> $stable(st_q)) else $error("deep mode left without reset");
	entry_delay_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q == CPD_RUN && timer_start && !emu_mask_q && !emu_attached)
		|=> (st_q == CPD_WAIT) ##[1:9] (st_q != CPD_WAIT)) else $error("entry delay wrong");
	emu_mask_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		emu_mask_q && st_q == CPD_WAIT |=> st_q == CPD_RUN) else $error("emulator mask ignored");
	isr_gate_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		isr_take |-> $past(ctl_q[CPD_GLOBAL_IRQ_BIT]) && $past(ctl_q[CPD_NONMASK_BIT]))
		else $error("isr without enables");
	resume_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q == CPD_GATE_ST && wake_any) |=> resume_pulse && st_q == CPD_RUN)
		else $error("no resume on wake");
	pd1e_hold_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q == CPD_GATE_ST && mode_q == CPD_CODE_IRQ_EN && !irq_enabled && !emu_mask_q)
		|=> st_q == CPD_GATE_ST) else $error("woke on disabled irq");
	io_freeze_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		(st_q == CPD_PLL_IN_ST) |=> io_freeze && pll_in_stop && !dma_allow)
		else $error("no freeze");
	res_bit_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
		!csr_q[CPD_FIELD_MSB]) else $error("reserved bit set");
endmodule

// file: sim/tb_cpu_power_down_control.sv
/*
 tb_cpu_power_down_control: self-checking bench for cpd_ctrl.
 assumes cpd_pkg and the design files are compiled first; bench is the axi master.
*/
`timescale 1ns/1ns
module tb_cpu_power_down_control import cpd_pkg::*;;
	logic        ref_clk = 1'h0;
	logic        sys_rst = 1'h1;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic [3:0]  wstrb = 4'h0;
	logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic        irq_pending = 1'h0, irq_enabled = 1'h0, emu_attached = 1'h0;
	logic        emu_exec_req = 1'h0, emu_pc_write = 1'h0;
	logic        cpu_clk_gate, cpu_halt, pll_out_stop, pll_in_stop, io_freeze, dma_allow;
	logic        isr_take, resume_pulse, emu_spin_idle, emu_pc_fail;
	int          isr_cnt = 0, res_cnt = 0;
	logic [31:0] seed = 32'h3b;
	int          bad_count = 0, checked = 0, cyc = 0;

	cpd_ctrl i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.irq_pending(irq_pending), .irq_enabled(irq_enabled), .emu_attached(emu_attached),
		.emu_exec_req(emu_exec_req), .emu_pc_write(emu_pc_write), .cpu_clk_gate(cpu_clk_gate),
		.cpu_halt(cpu_halt), .pll_out_stop(pll_out_stop), .pll_in_stop(pll_in_stop),
		.io_freeze(io_freeze), .dma_allow(dma_allow), .isr_take(isr_take),
		.resume_pulse(resume_pulse), .emu_spin_idle(emu_spin_idle), .emu_pc_fail(emu_pc_fail));

	always #5 ref_clk = ~ref_clk;

	// pulses last one cycle, so count them for later comparison
	always @(posedge ref_clk) begin
		if (isr_take === 1'h1) isr_cnt <= isr_cnt + 1;
		if (resume_pulse === 1'h1) res_cnt <= res_cnt + 1;
	end

	task automatic complete_run();
		$display("counts: checked %0d bad %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			complete_run();
		end
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction

	// top field bit reads back as zero whatever was written
	function automatic logic [5:0] exp_field(input logic [31:0] d);
		return {1'h0, d[14:10]};
	endfunction

	function automatic logic is_mode(input logic [5:0] c);
		return c == CPD_FIELD_NONE || c == CPD_CODE_IRQ_EN || c == CPD_CODE_IRQ_ANY ||
			c == CPD_CODE_PLL_OUT || c == CPD_CODE_PLL_IN;
	endfunction

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int   n;
		logic aw_ok, w_ok;
		n = 0;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge ref_clk);
			n++;
			if (!aw_ok && awready === 1'h1) begin
				aw_ok = 1'h1;
				awvalid <= 1'h0;
			end
			if (!w_ok && wready === 1'h1) begin
				w_ok = 1'h1;
				wvalid <= 1'h0;
			end
		end
		do begin
			@(posedge ref_clk);
			n++;
		end while (bvalid !== 1'h1);
		r = bresp;
		bready <= 1'h0;
		if (n >= 50) chk("write timeout", 0, 1);
		@(posedge ref_clk);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (arready !== 1'h1);
		arvalid <= 1'h0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (rvalid !== 1'h1);
		d = rdata;
		r = rresp;
		rready <= 1'h0;
		if (n >= 50) chk("read timeout", 0, 1);
		@(posedge ref_clk);
	endtask

	task automatic do_reset();
		sys_rst <= 1'h1;
		repeat (4) @(posedge ref_clk);
		sys_rst <= 1'h0;
		@(posedge ref_clk);
	endtask

	// entry takes up to nine cycles; wait a little beyond it
	task automatic enter(input logic [5:0] c);
		logic [1:0] r;
		axi_wr(CPD_CSR_OFS, {16'h0, c, 10'h0}, r);
		chk("csr bresp", CPD_RESP_OKAY, r);
		repeat (12) @(posedge ref_clk);
	endtask

	initial begin
		logic [31:0] d, rd;
		logic [1:0]  r;
		logic [5:0]  c;
		int          isr_base, res_base;
		do_reset();
		axi_rd(CPD_CSR_OFS, d, r);
		chk("csr reset", CPD_CSR_RST, d);
		chk("dma after reset", 1, dma_allow);
		axi_rd(8'h0c, d, r);
		chk("unmapped rresp", CPD_RESP_SLVERR, r);
		axi_wr(8'h0c, 32'h0, r);
		chk("unmapped bresp", CPD_RESP_SLVERR, r);
		$display("test registers done");
		for (int i = 0; i < 3; i++) begin
			c = (i == 2) ? CPD_CODE_IRQ_ANY : CPD_CODE_IRQ_EN;
			axi_wr(CPD_CTL_OFS, (i == 1) ? 32'h1 : 32'h3, r);
			enter(c);
			chk("halt", 1, cpu_halt);
			chk("clk gate", i == 2, cpu_clk_gate);
			chk("dma light", 1, dma_allow);
			axi_rd(CPD_STS_OFS, d, r);
			chk("status", {22'h0, 1'h0, c, CPD_GATE_ST}, d);
			isr_base = isr_cnt;
			res_base = res_cnt;
			irq_pending <= 1'h1;
			repeat (4) @(posedge ref_clk);
			chk("stay asleep", i < 2, cpu_halt);
			irq_enabled <= (i < 2);
			repeat (4) @(posedge ref_clk);
			chk("resume", 1, res_cnt - res_base);
			chk("isr", i == 0, isr_cnt - isr_base);
			chk("awake", 0, cpu_halt);
			irq_pending <= 1'h0;
			irq_enabled <= 1'h0;
			@(posedge ref_clk);
			$display("test light %0d done", i);
		end
		for (int i = 0; i < 2; i++) begin
			c = i ? CPD_CODE_PLL_IN : CPD_CODE_PLL_OUT;
			enter(c);
			chk("pll out", i == 0, pll_out_stop);
			chk("pll in", i == 1, pll_in_stop);
			chk("freeze", 1, io_freeze);
			chk("dma deep", 0, dma_allow);
			irq_pending <= 1'h1;
			irq_enabled <= 1'h1;
			emu_exec_req <= 1'h1;
			emu_pc_write <= 1'h1;
			repeat (6) @(posedge ref_clk);
			chk("deep hold", 1, cpu_halt);
			chk("spin idle", 1, emu_spin_idle);
			chk("pc fail", 1, emu_pc_fail);
			irq_pending <= 1'h0;
			irq_enabled <= 1'h0;
			emu_exec_req <= 1'h0;
			emu_pc_write <= 1'h0;
			do_reset();
			chk("deep exit", 0, pll_out_stop | pll_in_stop | io_freeze | cpu_halt);
			$display("test deep %0d done", i);
		end
		emu_attached <= 1'h1;
		enter(CPD_CODE_IRQ_EN);
		chk("emu mask", 0, cpu_halt);
		emu_attached <= 1'h0;
		do_reset();
		axi_wr(CPD_CTL_OFS, 32'h4, r);
		enter(CPD_CODE_IRQ_EN);
		chk("soft mask", 0, cpu_halt);
		do_reset();
		$display("test emulator done");
		for (int i = 0; i < 6; i++) begin
			seed = xs(seed);
			d = seed;
			d[15] = 1'h0;
			if (is_mode(exp_field(d))) d[13] = ~d[13];
			axi_wr(CPD_CSR_OFS, d, r);
			repeat (12) @(posedge ref_clk);
			chk("reserved code", 0, cpu_halt);
			axi_rd(CPD_CSR_OFS, rd, r);
			chk("field readback", exp_field(d), rd[15:10]);
		end
		$display("test reserved done");
		complete_run();
	end
endmodule
